// File: src/bps_pkg.sv
// constants, register map and state codes for the buck protection sequencer
// assumes a 50 mhz system clock and a byte-wide register port
package bps_pkg;
  // ************************
  // clock and timing
  // ************************
  localparam int CLK_KHZ = 50000;  // system clock rate
  localparam int CLK_NS = 20;  // system clock period
  localparam int BLANK_NS = 108;  // blanking after high-side turn-on
  localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;  // least time, rounded up
  localparam int US_CYC_DEF = CLK_KHZ / 1000;  // cycles per microsecond
  localparam int HICCUP_MV = 13500;  // inhibit time = this voltage / ramp rate
  localparam int VOUT_STEP_MV = 20;  // reference step per output code
  localparam logic [3:0] HIC_FULL = 4'hf;  // counter saturation code
  localparam logic [3:0] HIC_ZERO = 4'h0;
  // ************************
  // register map
  // ************************
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_SET1 = 3'h1;
  localparam logic [2:0] ADDR_SET2 = 3'h2;
  localparam logic [2:0] ADDR_VOUT = 3'h3;
  localparam logic [2:0] ADDR_CMD = 3'h4;
  localparam int CMD_CLR_BIT = 0;  // write one clears latched flags
  localparam logic [1:0] ILIM_RST = 2'h3;  // reset selections, plain defaults
  localparam logic [2:0] FREQ_RST = 3'h2;
  localparam logic [2:0] SUD_RST = 3'h0;
  localparam logic [1:0] MRG_RST = 2'h0;
  localparam logic [1:0] SS_RST = 2'h1;
  localparam logic [7:0] VOUT_RST = 8'h32;
  // ************************
  // selection tables
  // ************************
  function automatic int ss_rate_mv(input logic [1:0] s);  // mv per ms
    case (s)
      2'h0: return 160;
      2'h1: return 380;
      2'h2: return 760;
      default: return 1500;
    endcase
  endfunction : ss_rate_mv
  function automatic int freq_khz(input logic [2:0] f);
    case (f)
      3'h0: return 310;
      3'h1: return 400;
      3'h2: return 500;
      3'h3: return 570;
      3'h4: return 660;
      3'h5: return 780;
      3'h6: return 970;
      default: return 1200;
    endcase
  endfunction : freq_khz
  function automatic int sud_us(input logic [2:0] d);  // start-up delay
    case (d)
      3'h0: return 0;
      3'h1: return 1000;
      3'h2: return 2000;
      3'h3: return 3000;
      3'h4: return 4000;
      3'h5: return 5000;
      3'h6: return 7500;
      default: return 10000;
    endcase
  endfunction : sud_us
  function automatic int sw_period_cyc(input logic [2:0] f);
    return CLK_KHZ / freq_khz(f);
  endfunction : sw_period_cyc
  function automatic int ss_step_cyc(input logic [1:0] s);  // cycles per mv
    return CLK_KHZ / ss_rate_mv(s);
  endfunction : ss_step_cyc
  function automatic int hiccup_us(input logic [1:0] s);
    return HICCUP_MV * 1000 / ss_rate_mv(s);
  endfunction : hiccup_us
  // ************************
  // sequencer states
  // ************************
  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_DELAY = 6'h02,
    ST_SOFT = 6'h04,
    ST_RUN = 6'h08,
    ST_HIC = 6'h10,
    ST_THERM = 6'h20
  } bps_state_t;
endpackage : bps_pkg

// File: src/bps_top.sv
// start-up sequencing, switch control and protection of a step-down regulator
// assumes synchronous comparator inputs; rstn comes from supply undervoltage lockout
`timescale 1ns/1ps
`default_nettype none
module bps_top
  import bps_pkg::*;
#(
  parameter int US_CYC = US_CYC_DEF  // cycles per microsecond, shorten in simulation
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic en_i,
  input wire logic valley_cmp_i,
  input wire logic ls_limit_i,
  input wire logic hs_limit_i,
  input wire logic tsd_i,
  input wire logic twarn_i,
  input wire logic output_good_cmp_i,
  input wire logic good_pin_i,
  output logic good_pin_o,
  output logic good_pin_oe_n,
  output logic hs_gate,
  output logic ls_gate,
  output logic [1:0] ilim_sel,
  output logic [12:0] ref_mv
);
  // ************************
  // registers and state
  // ************************
  bps_state_t st_q, st_d;  // sequencer state
  logic [1:0] ilim_q;  // low-side limit level
  logic [2:0] freq_q, sud_q;  // frequency and delay codes
  logic [1:0] mrg_q, ss_q;  // margin and ramp codes
  logic [7:0] vout_q;  // output voltage code
  logic oc_flag_q, tsdf_q, twf_q;  // latched flags
  logic en_prev_q;  // for enable edge
  logic [23:0] wait_q;  // delay and inhibit timer
  logic [9:0] ss_cnt_q;  // ramp step prescaler
  logic [12:0] ref_q;  // reference in mv
  logic [7:0] per_q;  // switching period counter
  logic [3:0] hic_q;  // hiccup counter
  logic ls_evt_q;  // low-side event this period
  logic hs_q, ls_q, hs_done_q, ls_ok_q;  // switch drive
  logic [2:0] blank_q;  // blanking countdown
  logic [7:0] rdata_q;
  logic good_oe_n_q, good_o_q;  // open-drain output-good pin
  // ************************
  // combinational helpers
  // ************************
  logic act, sw_tick, clr_flags, hs_trip;
  logic [12:0] target_mv;
  // switching and hiccup counting only while ramping or running
  assign act = st_q == ST_SOFT || st_q == ST_RUN;  // soft-start or run: switching allowed
  assign sw_tick = per_q == 8'h00;  // clock event ends high-side time
  assign clr_flags = wr && addr == ADDR_CMD && wdata[CMD_CLR_BIT];
  assign hs_trip = hs_q && blank_q == 3'h0 && hs_limit_i;
  assign target_mv = 13'(vout_q * VOUT_STEP_MV);

  // ************************
  // register port
  // ************************
  // configuration writes; enable never touches these
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ilim_q <= ILIM_RST;
      freq_q <= FREQ_RST;
      sud_q <= SUD_RST;
      mrg_q <= MRG_RST;
      ss_q <= SS_RST;
      vout_q <= VOUT_RST;
    end else if (wr) begin
      case (addr)
        ADDR_SET1: begin
          ilim_q <= wdata[7:6];
          freq_q <= wdata[5:3];
        end
        ADDR_SET2: begin
          sud_q <= wdata[6:4];
          mrg_q <= wdata[3:2];
          ss_q <= wdata[1:0];
        end
        ADDR_VOUT: vout_q <= wdata;
        default: ;  // status and command hold nothing
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      case (addr)
        // bit 2 always one, bit 1 one while no fault flag is set
        ADDR_STATUS: rdata_q <= {oc_flag_q, tsdf_q, twf_q, 1'b0, en_i, 1'b1,
                                 ~(oc_flag_q | tsdf_q | twf_q), good_pin_i};
        ADDR_SET1: rdata_q <= {ilim_q, freq_q, 3'h0};
        ADDR_SET2: rdata_q <= {1'b0, sud_q, mrg_q, ss_q};
        ADDR_VOUT: rdata_q <= vout_q;
        default: rdata_q <= 8'h00;  // command and unmapped read zero
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // latched flags; a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oc_flag_q <= 1'b0;
      tsdf_q <= 1'b0;
      twf_q <= 1'b0;
    end else begin
      oc_flag_q <= (act && (ls_limit_i || hs_trip)) || (oc_flag_q && !clr_flags);
      tsdf_q <= tsd_i || (tsdf_q && !clr_flags);
      twf_q <= twarn_i || (twf_q && !clr_flags);
    end
  end

  // ************************
  // sequencer
  // ************************
  // enable and thermal shutdown override every other state
  always_comb begin
    st_d = st_q;
    if (!en_i) begin
      st_d = ST_OFF;
    end else if (tsd_i) begin
      st_d = ST_THERM;
    end else begin
      case (st_q)
        ST_OFF: if (!en_prev_q) st_d = ST_DELAY;
        ST_DELAY: if (wait_q == 24'h0) st_d = ST_SOFT;
        ST_SOFT: begin
          if (hic_q == HIC_FULL) st_d = ST_HIC;
          else if (ref_q >= target_mv) st_d = ST_RUN;
        end
        ST_RUN: if (hic_q == HIC_FULL) st_d = ST_HIC;
        ST_HIC: if (wait_q == 24'h0) st_d = ST_SOFT;
        ST_THERM: st_d = ST_SOFT;  // cooled: comparator carries the hysteresis
        default: st_d = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_OFF;
      en_prev_q <= 1'b0;
    end else begin
      st_q <= st_d;
      en_prev_q <= en_i;
    end
  end

  // one timer serves start-up delay and hiccup inhibit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 24'h0;
    end else if (st_d == ST_DELAY && st_q != ST_DELAY) begin
      wait_q <= 24'(sud_us(sud_q) * US_CYC);
    end else if (st_d == ST_HIC && st_q != ST_HIC) begin
      wait_q <= 24'(hiccup_us(ss_q) * US_CYC);
    end else if (wait_q != 24'h0) begin
      wait_q <= wait_q - 24'h1;
    end
  end

  // reference ramps one mv per step from zero on each fresh start
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_q <= 13'h0;
      ss_cnt_q <= 10'h0;
    end else if (st_q == ST_RUN) begin
      ref_q <= target_mv;  // tracks later output code changes
    end else if (st_q != ST_SOFT) begin
      ref_q <= 13'h0;
      ss_cnt_q <= 10'h0;
    end else if (ss_cnt_q == 10'h0) begin
      ss_cnt_q <= 10'(ss_step_cyc(ss_q) - 1);
      if (ref_q < target_mv) ref_q <= ref_q + 13'h1;
    end else begin
      ss_cnt_q <= ss_cnt_q - 10'h1;
    end
  end

  // ************************
  // switching and protection
  // ************************
  // period counter sets the switching frequency
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      per_q <= 8'h0;
    end else if (!act || sw_tick) begin
      per_q <= 8'(sw_period_cyc(freq_q) - 1);
    end else begin
      per_q <= per_q - 8'h1;
    end
  end

  // hiccup integration; only low-side events count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hic_q <= HIC_ZERO;
      ls_evt_q <= 1'b0;
    end else if (!act) begin
      hic_q <= HIC_ZERO;
      ls_evt_q <= 1'b0;
    end else if (sw_tick) begin
      ls_evt_q <= ls_limit_i;  // an event on the tick belongs to the new period
      if (ls_evt_q && hic_q != HIC_FULL) hic_q <= hic_q + 4'h1;
      else if (!ls_evt_q && hic_q != HIC_ZERO) hic_q <= hic_q - 4'h1;
    end else if (ls_limit_i) begin
      ls_evt_q <= 1'b1;
    end
  end

  // valley control: tick ends high-side, valley comparator starts it once per period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      hs_done_q <= 1'b0;
      ls_ok_q <= 1'b0;
      blank_q <= 3'h0;
    end else if (!act) begin
      hs_q <= 1'b0;  // both off: stage tri-stated
      ls_q <= 1'b0;
      hs_done_q <= 1'b0;
      ls_ok_q <= 1'b0;  // low-side waits for first high-side pulse
      blank_q <= 3'h0;
    end else if (sw_tick) begin
      hs_q <= 1'b0;
      ls_q <= ls_ok_q;
      hs_done_q <= 1'b0;
    end else if (hs_q) begin
      if (blank_q != 3'h0) begin
        blank_q <= blank_q - 3'h1;
      end else if (hs_limit_i) begin
        hs_q <= 1'b0;
        ls_q <= 1'b1;
      end
    end else if (!hs_done_q && valley_cmp_i && !ls_limit_i) begin
      hs_q <= 1'b1;
      ls_q <= 1'b0;
      hs_done_q <= 1'b1;
      ls_ok_q <= 1'b1;
      blank_q <= 3'(BLANK_CYC - 1);
    end
  end

  // output good pulls low unless running and in regulation
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      good_oe_n_q <= 1'b0;
      good_o_q <= 1'b0;
    end else begin
      good_oe_n_q <= st_q == ST_RUN && en_i && !tsd_i && output_good_cmp_i;
      good_o_q <= 1'b0;  // open drain only ever drives low
    end
  end

  assign rdata = rdata_q;
  assign good_pin_o = good_o_q;
  assign good_pin_oe_n = good_oe_n_q;
  assign hs_gate = hs_q;
  assign ls_gate = ls_q;
  assign ilim_sel = ilim_q;
  assign ref_mv = ref_q;

  // ************************
  // checks
  // ************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_hs_on_blocked: assert property ($rose(hs_q) |-> !$past(ls_limit_i))
    else $error("high-side turned on during low-side limit");
  a_hs_trip_ends: assert property (act && en_i && hs_trip |=> !hs_q)
    else $error("high-side limit did not end on-time");
  // blanking may only be cut short by the period tick or by leaving the switching states
  a_blank_masks: assert property (hs_q && blank_q != 3'h0 && act && !sw_tick
      |=> hs_q)
    else $error("high-side ended inside blanking");
  a_blank_load: assert property ($rose(hs_q) |-> blank_q == 3'(BLANK_CYC - 1))
    else $error("blanking not armed at high-side turn-on");
  a_hic_step_up: assert property (act && en_i && !tsd_i && sw_tick && ls_evt_q
      && hic_q != HIC_FULL |=> hic_q == $past(hic_q) + 4'h1)
    else $error("hiccup counter did not count up");
  a_hic_floor: assert property (act && en_i && sw_tick && !ls_evt_q
      && hic_q == HIC_ZERO |=> hic_q == HIC_ZERO)
    else $error("hiccup counter wrapped below zero");
  a_hic_inhibit: assert property (act && en_i && !tsd_i && hic_q == HIC_FULL
      |=> st_q == ST_HIC ##1 (!hs_q && !ls_q))
    else $error("full hiccup counter did not tri-state");
  a_tsd_stops: assert property (tsd_i |=> ##1 (!hs_q && !ls_q))
    else $error("stage still switching in thermal shutdown");
  a_good_drop: assert property (tsd_i |=> !good_oe_n_q)
    else $error("output good not dropped on thermal shutdown");
  a_flag_hold: assert property (oc_flag_q && !clr_flags |=> oc_flag_q)
    else $error("over-current flag lost without clear");
  a_hic_clear: assert property (!en_i |=> ##1 hic_q == HIC_ZERO)
    else $error("hiccup counter kept while disabled");
  a_ls_after_hs: assert property ($rose(ls_q) |-> ls_ok_q)
    else $error("low side turned on before any high-side pulse");
  a_tsd_flag: assert property (tsd_i |=> tsdf_q)
    else $error("thermal shutdown flag not set");

  c_hiccup: cover property (st_q == ST_RUN ##1 st_q == ST_HIC);
  c_hs_trip: cover property (hs_trip && act);
  c_restart: cover property (st_q == ST_HIC ##1 st_q == ST_SOFT);
  c_thermal: cover property (st_q == ST_THERM ##1 st_q == ST_SOFT);
  c_soft_hiccup: cover property (st_q == ST_SOFT ##1 st_q == ST_HIC);
endmodule : bps_top
`default_nettype wire

// File: testbench/bps_stage_model.sv
// power stage, current and thermal comparators and output-good pull-up
// assumes the bench sets fault levels at rising clock edges
`timescale 1ns/1ps
`default_nettype none
module bps_stage_model (
  input wire logic clk,
  input wire logic hs_gate,
  input wire logic ls_gate,
  input wire logic good_pin_o,
  input wire logic good_pin_oe_n,
  input wire logic [12:0] ref_mv,
  input wire logic [12:0] good_mv,
  input wire logic ls_over,
  input wire logic hs_over,
  input wire logic hot,
  input wire logic warm,
  output var logic valley_cmp_i,
  output var logic ls_limit_i,
  output var logic hs_limit_i,
  output var logic tsd_i,
  output var logic twarn_i,
  output var logic output_good_cmp_i,
  output wire logic good_pin_i
);
  // ************************
  // comparators
  // ************************
  // quiet comparators before the first edge
  initial begin
    {valley_cmp_i, ls_limit_i, hs_limit_i, tsd_i, twarn_i, output_good_cmp_i} = 6'h00;
  end
  // current is sensed only through a switch that conducts
  always @(posedge clk) begin
    valley_cmp_i <= ~hs_gate;  // inductor decays while high side is off
    ls_limit_i <= ls_over & ls_gate;
    hs_limit_i <= hs_over & hs_gate;
    tsd_i <= hot;  // hysteresis lives in when the bench drops hot
    twarn_i <= warm;
    output_good_cmp_i <= (ref_mv >= good_mv);
  end
  // open drain with pull-up: a released pin reads high
  assign good_pin_i = good_pin_oe_n ? 1'b1 : good_pin_o;
endmodule : bps_stage_model
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench: register port, start-up, switching and protection
// assumes bps_pkg, bps_top and the stage model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb
  import bps_pkg::*;
;
  // ************************
  // signals and instances
  // ************************
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic en_i = 1'b0;
  logic ls_over = 1'b0;
  logic hs_over = 1'b0;
  logic hot = 1'b0;
  logic warm = 1'b0;
  logic [12:0] good_mv = 13'h028;  // target for vout code 2
  wire logic [7:0] rdata;
  wire logic valley_cmp_i, ls_limit_i, hs_limit_i, tsd_i, twarn_i, output_good_cmp_i;
  wire logic good_pin_i, good_pin_o, good_pin_oe_n, hs_gate, ls_gate;
  wire logic [1:0] ilim_sel;
  wire logic [12:0] ref_mv;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int n, m, st;
  logic hs_seen, ls_early;  // low side seen before any high-side pulse
  int khz[8] = '{310, 400, 500, 570, 660, 780, 970, 1200};
  int rate[4] = '{160, 380, 760, 1500};
  int dly[4] = '{0, 3000, 7500, 10000};
  logic [2:0] sud[4] = '{3'h0, 3'h3, 3'h6, 3'h7};
  bps_top #(.US_CYC(1)) i_bps_top (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .en_i(en_i), .valley_cmp_i(valley_cmp_i),
    .ls_limit_i(ls_limit_i), .hs_limit_i(hs_limit_i), .tsd_i(tsd_i), .twarn_i(twarn_i),
    .output_good_cmp_i(output_good_cmp_i), .good_pin_i(good_pin_i), .good_pin_o(good_pin_o),
    .good_pin_oe_n(good_pin_oe_n),
    .hs_gate(hs_gate), .ls_gate(ls_gate), .ilim_sel(ilim_sel), .ref_mv(ref_mv));
  bps_stage_model i_bps_stage_model (.clk(clk), .hs_gate(hs_gate), .ls_gate(ls_gate),
    .good_pin_o(good_pin_o), .good_pin_oe_n(good_pin_oe_n), .ref_mv(ref_mv),
    .good_mv(good_mv), .ls_over(ls_over),
    .hs_over(hs_over), .hot(hot), .warm(warm), .valley_cmp_i(valley_cmp_i),
    .ls_limit_i(ls_limit_i), .hs_limit_i(hs_limit_i), .tsd_i(tsd_i), .twarn_i(twarn_i),
    .output_good_cmp_i(output_good_cmp_i), .good_pin_i(good_pin_i));
  // ************************
  // clock, watchdog, tasks
  // ************************
  always #10 clk = ~clk;
  // a hang is cut short well past the planned run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      $display("timeout after %0d cycles", cycles);
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input string name, input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(name, {8'h00, rdata}, {8'h00, exp});
  endtask : rd_chk
  // one cycle, watching for low side before the first high-side pulse
  task automatic step();
    @(posedge clk);
    #1;
    n++;
    if (hs_gate === 1'b1) hs_seen = 1'b1;
    if (ls_gate === 1'b1 && hs_seen !== 1'b1) ls_early = 1'b1;
  endtask : step
  // cycles up to the next high-side rising edge
  task automatic hs_rise(output int p);
    p = 0;
    while (hs_gate !== 1'b0 && p < 20000) begin
      @(posedge clk);
      #1;
      p++;
    end
    while (hs_gate !== 1'b1 && p < 20000) begin
      @(posedge clk);
      #1;
      p++;
    end
  endtask : hs_rise
  // ************************
  // tests
  // ************************
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd_chk("status", ADDR_STATUS, 8'h06);
    rd_chk("set1", ADDR_SET1, 8'hd0);
    rd_chk("set2", ADDR_SET2, 8'h01);
    rd_chk("vout", ADDR_VOUT, 8'h32);
    wr_reg(ADDR_STATUS, 8'hff);
    wr_reg(3'h5, 8'hff);
    rd_chk("status_ro", ADDR_STATUS, 8'h06);
    rd_chk("unmapped", 3'h5, 8'h00);
    rd_chk("cmd", ADDR_CMD, 8'h00);
    wr_reg(ADDR_SET2, 8'hff);
    rd_chk("set2_rsvd", ADDR_SET2, 8'h7f);
    wr_reg(ADDR_VOUT, 8'h01);
    $display("test registers done");
    // every ramp rate, with four delays; tiny target keeps fast ramps safe
    for (int i = 0; i < 4; i++) begin
      wr_reg(ADDR_SET2, {1'b0, sud[i], 2'h0, 2'(i)});
      @(posedge clk);
      en_i <= 1'b1;
      n = 0;
      hs_seen = 1'b0;
      ls_early = 1'b0;
      st = 50000 / rate[i];
      while (ref_mv === 13'h0 && n < 20000) step();
      chk("start_delay", 16'(n >= dly[i] + 2 && n <= dly[i] + 4), 16'h1);
      m = n;
      while (ref_mv !== 13'h014 && n < 30000) step();
      chk("ramp_time", 16'(n - m >= 19 * st - 2 && n - m <= 19 * st + 2), 16'h1);
      chk("prebias", {15'h0, ls_early}, 16'h0);
      @(posedge clk);
      en_i <= 1'b0;
      repeat (4) @(posedge clk);
      chk("gates_off", {14'h0, hs_gate, ls_gate}, 16'h0);
    end
    wr_reg(ADDR_VOUT, 8'h02);
    wr_reg(ADDR_SET2, 8'h03);
    @(posedge clk);
    en_i <= 1'b1;
    n = 0;
    while (good_pin_oe_n !== 1'b1 && n < 5000) step();
    rd_chk("status_good", ADDR_STATUS, 8'h0f);
    $display("test start-up done");
    // every frequency code, limit level follows the top bits
    for (int f = 0; f < 8; f++) begin
      wr_reg(ADDR_SET1, {f[1:0], 3'(f), 3'h0});
      rd_chk("set1_rb", ADDR_SET1, {f[1:0], 3'(f), 3'h0});
      chk("ilim_sel", {14'h0, ilim_sel}, {14'h0, f[1:0]});
      hs_rise(n);
      hs_rise(n);
      hs_rise(n);
      chk("period", 16'(n), 16'(50000 / khz[f]));
    end
    $display("test frequency done");
    // high-side trips: truncated after blanking, never a hiccup
    hs_over <= 1'b1;
    for (int k = 0; k < 20; k++) begin
      hs_rise(n);
      chk("no_hiccup", 16'(n < 100), 16'h1);
      m = 0;
      while (hs_gate === 1'b1 && m < 100) begin
        @(posedge clk);
        #1;
        m++;
      end
      chk("hs_width", 16'(m >= BLANK_CYC - 1 && m <= BLANK_CYC + 1), 16'h1);
    end
    hs_over <= 1'b0;
    repeat (60) @(posedge clk);
    rd_chk("oc_held", ADDR_STATUS, 8'h8d);
    wr_reg(ADDR_CMD, 8'h01);
    rd_chk("oc_clear", ADDR_STATUS, 8'h0f);
    $display("test high-side limit done");
    // lasting low-side overload: both switches off, then fresh soft-start
    @(posedge clk);
    ls_over <= 1'b1;
    n = 0;
    while ((hs_gate | ls_gate) !== 1'b0 && n < 2000) step();
    m = 0;
    while ((hs_gate | ls_gate) === 1'b0 && m < 12000) begin
      @(posedge clk);
      #1;
      m++;
    end
    n = 13500000 / rate[3];
    chk("inhibit", 16'(m >= n - 2 && m <= n + 5), 16'h1);
    chk("restart_ref", 16'(ref_mv <= 13'h2), 16'h1);
    // overload still present: the fresh ramp is cut short by another hiccup
    n = 0;
    while ((hs_gate | ls_gate) !== 1'b0 && n < 2000) step();
    ls_over <= 1'b0;
    chk("soft_hiccup", 16'(n < 1200), 16'h1);
    $display("test hiccup done");
    // thermal shutdown keeps the register port alive; first sit out the second inhibit
    n = 0;
    while (good_pin_oe_n !== 1'b1 && n < 12000) step();
    wr_reg(ADDR_CMD, 8'h01);
    @(posedge clk);
    hot <= 1'b1;
    warm <= 1'b1;
    repeat (4) @(posedge clk);
    chk("thermal_off", {13'h0, hs_gate, ls_gate, good_pin_oe_n}, 16'h0);
    rd_chk("thermal_status", ADDR_STATUS, 8'h6c);
    repeat (200) @(posedge clk);
    chk("thermal_hold", {13'h0, hs_gate, ls_gate, good_pin_oe_n}, 16'h0);
    hot <= 1'b0;
    warm <= 1'b0;
    hs_rise(n);
    chk("thermal_resume", 16'(n < 50 && ref_mv <= 13'h2), 16'h1);
    rd_chk("flags_kept", ADDR_STATUS, 8'h6c);
    @(posedge clk);
    en_i <= 1'b0;
    repeat (3) @(posedge clk);
    chk("en_off", {13'h0, hs_gate, ls_gate, good_pin_oe_n}, 16'h0);
    rd_chk("vout_kept", ADDR_VOUT, 8'h02);
    $display("test thermal and enable done");
    conclude();
  end
endmodule : tb
`default_nettype wire
